// ---- hdl/ssrp_pin_if.sv ----
// Bundle of synchronised pin levels and their edge pulses.
// Assumes producer and consumer share the system clock.
`timescale 1ns/100ps
interface ssrp_pin_if #(parameter int W = 4);
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface

// ---- hdl/ssrp_pkg.sv ----
// Constants and types shared by the serial register port.
// Assumes a single 200 MHz system clock samples every pin.
package ssrp_pkg;
   // Register index and byte geometry
   localparam int IDX_W = 8;
   localparam int BYTE_W = 8;
   localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
   localparam logic [2:0] SPI_LAST_BIT = 3'h7;
   // Fixed upper six bits of the 7-bit bus address
   localparam logic [5:0] I2C_ADDR_HI = 6'h34;
   // Direction bit values
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ = 1'h1;
   // Positions of the sampled pins in the synchroniser vector
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_CS_N = 2;
   localparam int PIN_ADSEL = 3;
   localparam int PIN_N = 4;
   // Values after reset
   localparam logic [PIN_N-1:0] PIN_RST = 4'hF;
   localparam logic [IDX_W-1:0] IDX_RST = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [3:0] I2C_CNT_RST = 4'h0;
   localparam logic [2:0] SPI_CNT_RST = 3'h0;
   // Byte-level phases of the two-wire side
   typedef enum logic [3:0] {
      I_IDLE, I_ADDR, I_ACK_ADDR, I_INDEX, I_ACK_INDEX, I_WDATA, I_ACK_WDATA,
      I_RDATA, I_MACK, I_RLOAD, I_WAIT
   } ssrp_i2c_state_t;
endpackage

// ---- hdl/ssrp_sync.sv ----
// Two-flop synchroniser with edge detection for a vector of pins.
// Assumes pins are asynchronous to clk_in; edges lag the pin by two cycles.
`timescale 1ns/100ps
module ssrp_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Raw pins
   input wire logic [W-1:0] raw_in,
   // Synchronised view
   ssrp_pin_if.src pins_out
);
   logic [W-1:0] meta;
   logic [W-1:0] stable;
   logic [W-1:0] prev;

   // First stage is read by the second stage only
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta <= RST_VAL;
         stable <= RST_VAL;
         prev <= RST_VAL;
      end else begin
         meta <= raw_in;
         stable <= meta;
         prev <= stable;
      end
   end

   assign pins_out.lvl = stable;
   assign pins_out.rise = stable & ~prev;
   assign pins_out.fall = ~stable & prev;
endmodule

// ---- hdl/ssrp_top.sv ----
// Serial register port: two-wire and four-wire slave in front of a register file.
// Assumes the register file answers reg_rd_out with reg_rdata_in one cycle later.
`timescale 1ns/100ps
module ssrp_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Two-wire bus, shared with four-wire clock and data in
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   input wire logic address_select_pin_in,
   // Four-wire select and data out
   input wire logic cs_n_in,
   output logic sdo_out,
   output logic sdo_oe_n_out,
   // Register file side
   output logic [ssrp_pkg::IDX_W-1:0] reg_addr_out,
   output logic [ssrp_pkg::BYTE_W-1:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [ssrp_pkg::BYTE_W-1:0] reg_rdata_in
);
   ssrp_pin_if #(.W(ssrp_pkg::PIN_N)) pins ();

   ssrp_sync #(.W(ssrp_pkg::PIN_N), .RST_VAL(ssrp_pkg::PIN_RST)) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .raw_in({address_select_pin_in, cs_n_in, sda_in, scl_in}),
      .pins_out(pins)
   );

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic sda_rise;
   logic sda_fall;
   logic spi_sel;
   logic adsel;
   assign scl = pins.lvl[ssrp_pkg::PIN_SCL];
   assign sda = pins.lvl[ssrp_pkg::PIN_SDA];
   assign scl_rise = pins.rise[ssrp_pkg::PIN_SCL];
   assign scl_fall = pins.fall[ssrp_pkg::PIN_SCL];
   assign sda_rise = pins.rise[ssrp_pkg::PIN_SDA];
   assign sda_fall = pins.fall[ssrp_pkg::PIN_SDA];
   assign spi_sel = ~pins.lvl[ssrp_pkg::PIN_CS_N];
   assign adsel = pins.lvl[ssrp_pkg::PIN_ADSEL];

   // Shared register index and read data
   logic [ssrp_pkg::IDX_W-1:0] reg_index;
   logic [ssrp_pkg::BYTE_W-1:0] rdata_q;
   logic rd_q;

   // Two-wire side
   ssrp_pkg::ssrp_i2c_state_t i_state;
   logic [3:0] i_cnt;
   logic [ssrp_pkg::BYTE_W-1:0] i_sh;
   logic i_drive;
   logic i_start;
   logic i_stop;
   logic i_byte_done;
   logic i_addr_hit;
   logic i_ev_rd;
   logic i_ev_idx;
   logic i_ev_wr;
   logic i_ev_inc;

   assign i_start = sda_fall & scl & ~spi_sel;
   assign i_stop = sda_rise & scl & ~spi_sel;
   assign i_byte_done = scl_fall & (i_cnt == ssrp_pkg::I2C_BYTE_BITS);
   assign i_addr_hit = (i_sh[7:1] == {ssrp_pkg::I2C_ADDR_HI, adsel});

   // read request once the read address is taken
   assign i_ev_rd = ~spi_sel & ~i_start & ~i_stop & (i_state == ssrp_pkg::I_ADDR)
                    & i_byte_done & i_addr_hit & (i_sh[0] == ssrp_pkg::DIR_READ);
   // first byte after write address is the index
   assign i_ev_idx = ~spi_sel & ~i_start & ~i_stop & (i_state == ssrp_pkg::I_INDEX)
                     & i_byte_done;
   assign i_ev_wr = ~spi_sel & ~i_start & ~i_stop & (i_state == ssrp_pkg::I_WDATA)
                    & i_byte_done;
   // master ack asks for the next register
   assign i_ev_inc = ~spi_sel & ~i_start & ~i_stop & (i_state == ssrp_pkg::I_MACK)
                     & scl_rise & ~sda;

   // Two-wire byte engine; stretching SCL is never used, so reads must be ready early
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         i_state <= ssrp_pkg::I_IDLE;
         i_cnt <= ssrp_pkg::I2C_CNT_RST;
         i_sh <= ssrp_pkg::BYTE_RST;
         i_drive <= 1'b0;
      end else if (spi_sel || i_stop) begin
         i_state <= ssrp_pkg::I_IDLE;
         i_drive <= 1'b0;
      end else if (i_start) begin
         // Repeated start lands here as well
         i_state <= ssrp_pkg::I_ADDR;
         i_cnt <= ssrp_pkg::I2C_CNT_RST;
         i_drive <= 1'b0;
      end else begin
         unique case (i_state)
            ssrp_pkg::I_IDLE, ssrp_pkg::I_WAIT: begin
               i_drive <= 1'b0;
            end
            ssrp_pkg::I_ADDR, ssrp_pkg::I_INDEX, ssrp_pkg::I_WDATA: begin
               if (scl_rise && i_cnt != ssrp_pkg::I2C_BYTE_BITS) begin
                  i_sh <= {i_sh[6:0], sda};
                  i_cnt <= i_cnt + 4'h1;
               end
               if (i_byte_done) begin
                  i_cnt <= ssrp_pkg::I2C_CNT_RST;
                  if (i_state == ssrp_pkg::I_ADDR) begin
                     i_drive <= i_addr_hit;
                     // direction bit steers the phase after acknowledge
                     i_state <= i_addr_hit ? ssrp_pkg::I_ACK_ADDR : ssrp_pkg::I_WAIT;
                  end else begin
                     i_drive <= 1'b1;
                     i_state <= (i_state == ssrp_pkg::I_INDEX) ? ssrp_pkg::I_ACK_INDEX
                                                               : ssrp_pkg::I_ACK_WDATA;
                  end
               end
            end
            ssrp_pkg::I_ACK_ADDR: begin
               if (scl_fall) begin
                  if (i_sh[0] == ssrp_pkg::DIR_READ) begin
                     i_drive <= ~rdata_q[7];
                     i_sh <= {rdata_q[6:0], 1'b0};
                     i_cnt <= 4'h1;
                     i_state <= ssrp_pkg::I_RDATA;
                  end else begin
                     i_drive <= 1'b0;
                     i_state <= ssrp_pkg::I_INDEX;
                  end
               end
            end
            ssrp_pkg::I_ACK_INDEX, ssrp_pkg::I_ACK_WDATA: begin
               if (scl_fall) begin
                  i_drive <= 1'b0;
                  i_state <= ssrp_pkg::I_WDATA;
               end
            end
            ssrp_pkg::I_RDATA: begin
               if (scl_fall) begin
                  if (i_cnt == ssrp_pkg::I2C_BYTE_BITS) begin
                     // Release for the master's acknowledge
                     i_drive <= 1'b0;
                     i_state <= ssrp_pkg::I_MACK;
                  end else begin
                     i_drive <= ~i_sh[7];
                     i_sh <= {i_sh[6:0], 1'b0};
                     i_cnt <= i_cnt + 4'h1;
                  end
               end
            end
            ssrp_pkg::I_MACK: begin
               // high on the ninth clock ends the read
               if (scl_rise) begin
                  i_state <= sda ? ssrp_pkg::I_WAIT : ssrp_pkg::I_RLOAD;
               end
            end
            ssrp_pkg::I_RLOAD: begin
               if (scl_fall) begin
                  i_drive <= ~rdata_q[7];
                  i_sh <= {rdata_q[6:0], 1'b0};
                  i_cnt <= 4'h1;
                  i_state <= ssrp_pkg::I_RDATA;
               end
            end
         endcase
      end
   end

   // Open drain: only ever pulls low
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sda_out <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end else begin
         sda_out <= 1'b0;
         sda_oe_n_out <= ~i_drive;
      end
   end

   // Four-wire side; clock and select are inputs only
   logic [2:0] s_cnt;
   logic [ssrp_pkg::BYTE_W-1:0] s_sh;
   logic [ssrp_pkg::BYTE_W-1:0] s_out;
   logic s_first;
   logic s_rw;
   logic s_byte_done;
   logic s_ev_idx;
   logic s_ev_rd;
   logic s_ev_inc;
   logic s_ev_wr;
   logic s_load;

   assign s_byte_done = spi_sel & scl_rise & (s_cnt == ssrp_pkg::SPI_LAST_BIT);
   // first byte is the address byte
   assign s_ev_idx = s_byte_done & s_first;
   // MSB of the address byte selects read
   assign s_ev_rd = s_ev_idx & (s_sh[6] == ssrp_pkg::DIR_READ);
   assign s_ev_inc = s_byte_done & ~s_first & (s_rw == ssrp_pkg::DIR_READ);
   assign s_ev_wr = s_byte_done & ~s_first & (s_rw == ssrp_pkg::DIR_WRITE);
   assign s_load = spi_sel & scl_fall & ~s_first & (s_rw == ssrp_pkg::DIR_READ);

   // select frames the transfer and resets the byte engine
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_cnt <= ssrp_pkg::SPI_CNT_RST;
         s_sh <= ssrp_pkg::BYTE_RST;
         s_first <= 1'b1;
         s_rw <= ssrp_pkg::DIR_WRITE;
      end else if (!spi_sel) begin
         s_cnt <= ssrp_pkg::SPI_CNT_RST;
         s_first <= 1'b1;
         s_rw <= ssrp_pkg::DIR_WRITE;
      end else if (scl_rise) begin
         // sample on the rising edge, MSB first
         s_sh <= {s_sh[6:0], sda};
         s_cnt <= s_cnt + 3'h1;
         if (s_ev_idx) begin
            s_first <= 1'b0;
            s_rw <= s_sh[6];
         end
      end
   end

   // data out changes on falling edges only; first byte right after address
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_out <= ssrp_pkg::BYTE_RST;
         sdo_out <= 1'b0;
         sdo_oe_n_out <= 1'b1;
      end else if (!spi_sel) begin
         sdo_oe_n_out <= 1'b1;
      end else if (s_load) begin
         sdo_oe_n_out <= 1'b0;
         if (s_cnt == ssrp_pkg::SPI_CNT_RST) begin
            sdo_out <= rdata_q[7];
            s_out <= {rdata_q[6:0], 1'b0};
         end else begin
            sdo_out <= s_out[7];
            s_out <= {s_out[6:0], 1'b0};
         end
      end
   end

   // Register access; the two links never act in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_index <= ssrp_pkg::IDX_RST;
         reg_addr_out <= ssrp_pkg::IDX_RST;
         reg_wdata_out <= ssrp_pkg::BYTE_RST;
         reg_wr_out <= 1'b0;
         reg_rd_out <= 1'b0;
      end else begin
         reg_wr_out <= 1'b0;
         reg_rd_out <= 1'b0;
         if (s_ev_idx) begin
            // low seven bits give the index
            reg_index <= {1'b0, s_sh[5:0], sda};
            reg_addr_out <= {1'b0, s_sh[5:0], sda};
            reg_rd_out <= s_ev_rd;
         end else if (i_ev_idx) begin
            reg_index <= i_sh;
         end else if (s_ev_wr || i_ev_wr) begin
            reg_wr_out <= 1'b1;
            reg_addr_out <= reg_index;
            reg_wdata_out <= s_ev_wr ? {s_sh[6:0], sda} : i_sh;
            reg_index <= reg_index + 8'h01;
         end else if (s_ev_inc || i_ev_inc) begin
            // advance and fetch the next register
            reg_rd_out <= 1'b1;
            reg_addr_out <= reg_index + 8'h01;
            reg_index <= reg_index + 8'h01;
         end else if (i_ev_rd) begin
            reg_rd_out <= 1'b1;
            reg_addr_out <= reg_index;
         end
      end
   end

   // Read data is taken one cycle after the request
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_q <= 1'b0;
         rdata_q <= ssrp_pkg::BYTE_RST;
      end else begin
         rd_q <= reg_rd_out;
         if (rd_q) begin
            rdata_q <= reg_rdata_in;
         end
      end
   end

   // Checks
   chk_sdo_hiz_desel: assert property (
      @(posedge clk_in) disable iff (!rst_n_in) !spi_sel |=> sdo_oe_n_out)
      else $error("SDO driven while deselected");

   chk_spi_index_load: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_ev_idx |=> reg_index == {1'b0, $past(s_sh[5:0]), $past(sda)})
      else $error("Index not taken from address byte");

   chk_spi_read_req: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_ev_idx |=> (reg_rd_out == $past(s_sh[6])) && !reg_wr_out)
      else $error("Direction bit not honoured");

   chk_spi_first_data: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_load && s_cnt == ssrp_pkg::SPI_CNT_RST |=> sdo_out == $past(rdata_q[7]) && !sdo_oe_n_out)
      else $error("Read byte not started with its MSB");

   chk_sdo_fall_only: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      $changed(sdo_out) |-> $past(scl_fall) && $past(spi_sel))
      else $error("SDO changed away from a falling edge");

   chk_burst_write_inc: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (s_ev_wr || i_ev_wr) |=> reg_wr_out && reg_addr_out == $past(reg_index)
         && reg_index == $past(reg_index) + 8'h01)
      else $error("Burst write did not advance index");

   chk_burst_read_inc: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (s_ev_inc || i_ev_inc) |=> reg_rd_out && reg_addr_out == $past(reg_index) + 8'h01
         ##2 rdata_q == $past(reg_rdata_in))
      else $error("Burst read did not fetch next register");

   chk_i2c_addr_ack: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (i_state == ssrp_pkg::I_ADDR) && i_byte_done && !i_start && !i_stop && !spi_sel
      |=> ##1 sda_oe_n_out == !$past(i_addr_hit, 2))
      else $error("Address acknowledge wrong");

   chk_i2c_nack_ends: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (i_state == ssrp_pkg::I_MACK) && scl_rise && sda && !i_stop && !i_start && !spi_sel
      |=> (i_state == ssrp_pkg::I_WAIT) && !reg_rd_out)
      else $error("Read continued after refusal");

   cov_spi_read: cover property (@(posedge clk_in) disable iff (!rst_n_in) s_ev_rd);
   cov_spi_write: cover property (@(posedge clk_in) disable iff (!rst_n_in) s_ev_wr);
   cov_i2c_burst_read: cover property (@(posedge clk_in) disable iff (!rst_n_in) i_ev_inc);
   cov_i2c_write: cover property (@(posedge clk_in) disable iff (!rst_n_in) i_ev_wr);
endmodule

// ---- verification/ssrp_host_model.sv ----
// Host master model driving the two-wire and four-wire links by task.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/100ps
module ssrp_host_model (
   // Clock
   input wire logic clk_in,
   // Resolved wires seen by the host
   input wire logic sda_wire_in,
   input wire logic miso_in,
   // Host drives
   output logic scl_out,
   output logic sda_out,
   output logic cs_n_out
);
   // Lines idle high, matching the synchroniser reset level
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
      cs_n_out = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic i2c_start();
      scl_out <= 1'b0;
      tick(6);
      sda_out <= 1'b1;
      tick(6);
      scl_out <= 1'b1;
      tick(13);
      sda_out <= 1'b0;
      tick(13);
   endtask
   task automatic i2c_stop();
      scl_out <= 1'b0;
      tick(6);
      sda_out <= 1'b0;
      tick(6);
      scl_out <= 1'b1;
      tick(13);
      sda_out <= 1'b1;
      tick(13);
   endtask
   // data moves only while the clock is low
   task automatic i2c_bit(input logic b, output logic s);
      scl_out <= 1'b0;
      tick(6);
      sda_out <= b;
      tick(6);
      scl_out <= 1'b1;
      tick(6);
      s = sda_wire_in;
      tick(7);
   endtask
   task automatic i2c_byte(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                           output logic ack_seen);
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(tx[i], rx[i]);
      end
      i2c_bit(ack, ack_seen);
   endtask
   task automatic spi_frame(input logic on);
      sda_out <= 1'b1;
      tick(4);
      cs_n_out <= ~on;
      tick(10);
   endtask
   // MSB first, change on fall, sample on rise
   task automatic spi_bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         scl_out <= 1'b0;
         sda_out <= tx[i];
         tick(12);
         scl_out <= 1'b1;
         rx[i] = miso_in;
         tick(13);
      end
   endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the serial register port with a host model on the links.
// Assumes a register file that answers from the held address; reads give addr ^ 5C.
`timescale 1ns/100ps
module testbench;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic address_select_pin_in = 1'b0;
   logic scl, sda_m, cs_n, sda_wire, miso;
   logic sdo_last = 1'b0;
   logic sda_out, sda_oe_n_out, sdo_out, sdo_oe_n_out, reg_wr_out, reg_rd_out;
   logic [ssrp_pkg::IDX_W-1:0] reg_addr_out;
   logic [ssrp_pkg::BYTE_W-1:0] reg_wdata_out, reg_rdata_in;
   logic [7:0] wa[$];
   logic [7:0] wd[$];
   int err_count = 0;
   int check_count = 0;
   always #2.5 clk_in = ~clk_in;
   // Pull-up unless the host or the device pulls low
   assign sda_wire = sda_m & (sda_oe_n_out | sda_out);
   // Released SDO shows the inverse of its last value, never a lucky match
   assign miso = sdo_oe_n_out ? ~sdo_last : sdo_out;
   assign reg_rdata_in = reg_addr_out ^ 8'h5C;
   always @(posedge clk_in) begin
      if (sdo_oe_n_out === 1'b0) begin
         sdo_last <= sdo_out;
      end
      if (reg_wr_out === 1'b1) begin
         wa.push_back(reg_addr_out);
         wd.push_back(reg_wdata_out);
      end
   end
   ssrp_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
      .address_select_pin_in(address_select_pin_in), .cs_n_in(cs_n), .sdo_out(sdo_out),
      .sdo_oe_n_out(sdo_oe_n_out), .reg_addr_out(reg_addr_out),
      .reg_wdata_out(reg_wdata_out), .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out),
      .reg_rdata_in(reg_rdata_in));
   ssrp_host_model host (.clk_in(clk_in), .sda_wire_in(sda_wire), .miso_in(miso),
      .scl_out(scl), .sda_out(sda_m), .cs_n_out(cs_n));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic t_reset();
      repeat (16) @(posedge clk_in);
      #1;
      chk("sda_oe_n in reset", 8'h01, {7'h00, sda_oe_n_out});
      chk("sdo_oe_n in reset", 8'h01, {7'h00, sdo_oe_n_out});
      chk("strobes in reset", 8'h00, {6'h00, reg_wr_out, reg_rd_out});
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (10) @(posedge clk_in);
   endtask
   task automatic t_spi_write();
      logic [7:0] rx;
      wa.delete();
      wd.delete();
      host.spi_frame(1'b1);
      host.spi_bits(8'h15, 8, rx);
      host.spi_bits(8'hA1, 8, rx);
      host.spi_bits(8'hB2, 8, rx);
      host.spi_frame(1'b0);
      chk("spi write count", 8'h02, 8'(wa.size()));
      chk("spi write addr 0", 8'h15, wa[0]);
      chk("spi write data 0", 8'hA1, wd[0]);
      chk("spi write addr 1", 8'h16, wa[1]);
      chk("spi write data 1", 8'hB2, wd[1]);
   endtask
   task automatic t_spi_read();
      logic [7:0] rx;
      wa.delete();
      host.spi_frame(1'b1);
      chk("sdo_oe_n before data", 8'h01, {7'h00, sdo_oe_n_out});
      host.spi_bits(8'hFE, 8, rx);
      host.spi_bits(8'h00, 8, rx);
      chk("spi read byte 0", 8'h7E ^ 8'h5C, rx);
      host.spi_bits(8'h00, 8, rx);
      chk("spi read byte 1", 8'h7F ^ 8'h5C, rx);
      host.spi_frame(1'b0);
      chk("sdo_oe_n after frame", 8'h01, {7'h00, sdo_oe_n_out});
      chk("spi read writes", 8'h00, 8'(wa.size()));
   endtask
   task automatic t_spi_short();
      logic [7:0] rx;
      wa.delete();
      wd.delete();
      host.spi_frame(1'b1);
      host.spi_bits(8'h05, 8, rx);
      host.spi_frame(1'b0);
      chk("address only frame", 8'h00, 8'(wa.size()));
      host.spi_frame(1'b1);
      host.spi_bits(8'h05, 8, rx);
      host.spi_bits(8'hC3, 8, rx);
      host.spi_bits(8'h90, 4, rx);
      host.spi_frame(1'b0);
      chk("partial byte dropped", 8'h01, 8'(wa.size()));
      chk("short frame data", 8'hC3, wd[0]);
      chk("short frame addr", 8'h05, wa[0]);
   endtask
   task automatic t_i2c_write();
      logic [7:0] rx;
      logic ack;
      wa.delete();
      wd.delete();
      address_select_pin_in <= 1'b0;
      host.i2c_start();
      host.i2c_byte(8'hD0, 1'b1, rx, ack);
      chk("i2c write addr ack", 8'h00, {7'h00, ack});
      host.i2c_byte(8'h20, 1'b1, rx, ack);
      chk("i2c index ack", 8'h00, {7'h00, ack});
      host.i2c_byte(8'h5A, 1'b1, rx, ack);
      host.i2c_byte(8'h6B, 1'b1, rx, ack);
      chk("i2c data ack", 8'h00, {7'h00, ack});
      host.i2c_stop();
      chk("i2c write addr 0", 8'h20, wa[0]);
      chk("i2c write data 0", 8'h5A, wd[0]);
      chk("i2c write addr 1", 8'h21, wa[1]);
      chk("i2c write data 1", 8'h6B, wd[1]);
   endtask
   task automatic t_i2c_read();
      logic [7:0] rx;
      logic ack;
      address_select_pin_in <= 1'b1;
      host.i2c_start();
      host.i2c_byte(8'hD2, 1'b1, rx, ack);
      chk("i2c addr ack sel high", 8'h00, {7'h00, ack});
      host.i2c_byte(8'h30, 1'b1, rx, ack);
      host.i2c_start();
      host.i2c_byte(8'hD3, 1'b1, rx, ack);
      chk("i2c read addr ack", 8'h00, {7'h00, ack});
      host.i2c_byte(8'hFF, 1'b0, rx, ack);
      chk("i2c read byte 0", 8'h30 ^ 8'h5C, rx);
      host.i2c_byte(8'hFF, 1'b1, rx, ack);
      chk("i2c read byte 1", 8'h31 ^ 8'h5C, rx);
      host.i2c_stop();
      chk("sdo_oe_n during i2c", 8'h01, {7'h00, sdo_oe_n_out});
   endtask
   task automatic t_i2c_wrong();
      logic [7:0] rx;
      logic ack;
      wa.delete();
      host.i2c_start();
      host.i2c_byte(8'hD0, 1'b1, rx, ack);
      chk("other address ignored", 8'h01, {7'h00, ack});
      host.i2c_byte(8'h40, 1'b1, rx, ack);
      host.i2c_byte(8'h11, 1'b1, rx, ack);
      host.i2c_stop();
      chk("no write for other address", 8'h00, 8'(wa.size()));
   endtask
   // Watchdog so a stuck link ends the run with a verdict
   initial begin
      repeat (100000) @(posedge clk_in);
      err_count++;
      results();
   end
   initial begin
      t_reset();
      t_spi_write();
      t_spi_read();
      t_spi_short();
      t_i2c_write();
      t_i2c_read();
      t_i2c_wrong();
      results();
   end
endmodule
